// ### bench/uart_echo_wakeup_bench.sv
// self-checking bench for the echo and wake-up serial channel
// assumes the checker is bound and the remote station drives rxd
`include "uart_echo_defs.svh"
`default_nettype none

module uart_echo_wakeup_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk, sys_rst, cs, rd, wr;
	logic [5:0]  adr;
	logic [3:0]  be;
	logic [31:0] wd, rdat, q;
	logic        wreq, txd, mpo, irq;
	wire logic   rxd;
	int          n_fail = 0;
	int          checks = 0;

	uart_echo_wakeup u_uart_echo_wakeup (.mclk(mclk), .sys_rst(sys_rst),
		.avs_chipselect(cs), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_byteenable(be), .avs_writedata(wd), .avs_readdata(rdat),
		.avs_waitrequest(wreq), .rxd(rxd), .txd(txd), .mpo(mpo), .irq(irq));
	uart_remote_station u_uart_remote_station (.mclk(mclk), .rxd(rxd));

	// -----------------------------
	// shared tasks
	// -----------------------------
	task finish_test();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// request held until waitrequest is seen low at a rising edge
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		cs <= 1'b1;
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		n = 0;
		// waitrequest is judged at the rising edge that also commits the access
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (wreq !== 1'b0 && n < 20);
		if (wreq !== 1'b0)
		begin
			n_fail++;
			finish_test();
		end
		else
		begin
			q = rdat;
			cs <= 1'b0;
			rd <= 1'b0;
			wr <= 1'b0;
		end
	endtask

	task rd_chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		cmp(q & m, e);
	endtask

	// -----------------------------
	// scenarios
	// -----------------------------
	task t_regs();
		rd_chk(`OFS_MODE_TWO, 32'hff, 32'h0);
		rd_chk(6'h3c, 32'hffffffff, 32'h0);
		bus(1'b1, `OFS_MODE_TWO, 32'h41);
		rd_chk(`OFS_MODE_TWO, 32'hff, 32'h41);
		$display("t_regs done");
	endtask

	// echo on, receiver and transmitter off, seven-bit wake-up mode
	task t_wake();
		bus(1'b1, `OFS_MODE_ONE, 32'h3);
		bus(1'b1, `OFS_IRQ_ENABLE, 32'h1);
		bus(1'b1, `OFS_TX_DATA, 32'h5a);
		fork
			u_uart_remote_station.send(8'h85);
			begin
				repeat (4000) @(posedge mclk);
				cmp({31'h0, txd}, 32'h0);
			end
		join
		repeat (10) @(posedge mclk);
		rd_chk(`OFS_STATUS, 32'h1, 32'h1);
		cmp({31'h0, mpo}, 32'h1);
		cmp({31'h0, irq}, 32'h1);
		rd_chk(`OFS_RX_DATA, 32'h1ff, 32'h105);
		repeat (3) @(posedge mclk);
		cmp({31'h0, mpo}, 32'h0);
		bus(1'b1, `OFS_IRQ_CLEAR, 32'h1);
		// the clear lands on the commit edge; look one edge later
		@(posedge mclk);
		cmp({31'h0, irq}, 32'h0);
		$display("t_wake done");
	endtask

	// back to normal mode: data characters dropped, host path restored
	task t_drop();
		bus(1'b1, `OFS_MODE_TWO, 32'h0);
		bus(1'b1, `OFS_CTRL, 32'h2);
		repeat (2000) @(posedge mclk);
		cmp({31'h0, txd}, 32'h1);
		bus(1'b1, `OFS_TX_DATA, 32'h5a);
		fork
			u_uart_remote_station.send(8'h06);
			begin
				repeat (3000) @(posedge mclk);
				cmp({31'h0, txd}, 32'h0);
			end
		join
		repeat (10) @(posedge mclk);
		rd_chk(`OFS_STATUS, 32'h1, 32'h0);
		cmp({31'h0, irq}, 32'h0);
		$display("t_drop done");
	endtask

	// -----------------------------
	// clock and main sequence
	// -----------------------------
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	initial
	begin
		sys_rst = 1'b1;
		cs = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		adr = 6'h0;
		be = 4'hf;
		wd = 32'h0;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		t_regs();
		t_wake();
		t_drop();
		finish_test();
	end
endmodule

`default_nettype wire

// ### bench/uart_echo_wakeup_chk.sv
// port checker for the echo and wake-up serial channel
// assumes it is bound to uart_echo_wakeup and sees only its ports
`include "uart_echo_defs.svh"
`default_nettype none

module uart_echo_wakeup_chk
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        sys_rst,
	// avalon-mm slave
	input wire logic        avs_chipselect,
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// serial and host pins
	input wire logic        rxd,
	input wire logic        txd,
	input wire logic        mpo,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;

	logic access;
	logic wr_done;
	logic echo_r;
	logic sel_r;
	logic ien_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// -----------------------------
	// settings as software commits them
	// -----------------------------
	assign access = avs_chipselect && (avs_read || avs_write);
	assign wr_done = access && avs_write && !avs_waitrequest && avs_byteenable[0];
	// mirrors only what the antecedents need, not the whole register file
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			echo_r <= 1'b0;
			sel_r <= 1'b0;
			ien_r <= 1'b0;
		end
		else if (wr_done && {avs_address[5:2], 2'h0} == `OFS_MODE_TWO)
		begin
			echo_r <= avs_writedata[7:6] == `CHMODE_ECHO;
			sel_r <= avs_writedata[0];
		end
		else if (wr_done && {avs_address[5:2], 2'h0} == `OFS_IRQ_ENABLE)
			ien_r <= |avs_writedata[2:0];
	end

	// -----------------------------
	// assertions
	// -----------------------------
	// echo delay is one tick plus sync, well under 900 cycles
	sequence s_echo_low;
		##[1:900] !txd;
	endsequence
	sequence s_echo_high;
		##[1:900] txd;
	endsequence

	chk_first_wait: assert property ($rose(access) |-> avs_waitrequest)
		else $error("no wait state in first access cycle");
	chk_one_wait: assert property (access && avs_waitrequest |=> !access || !avs_waitrequest)
		else $error("more than one wait state");
	chk_idle_wait: assert property (!access |-> !avs_waitrequest)
		else $error("waitrequest without access");
	chk_rdata_hold: assert property ($changed(avs_readdata) |-> access && !avs_waitrequest)
		else $error("readdata changed outside an access");
	chk_reset_idle: assert property ($fell(sys_rst) |-> txd && !mpo && !irq)
		else $error("pins not idle after reset");
	chk_start_width: assert property ($fell(txd) |=> !txd [*8])
		else $error("short low pulse on txd");
	chk_echo_fall: assert property (echo_r && $fell(rxd) |-> s_echo_low)
		else $error("falling edge not echoed");
	chk_echo_rise: assert property (echo_r && $rose(rxd) |-> s_echo_high)
		else $error("rising edge not echoed");
	chk_mpo_off: assert property (!sel_r && !$past(sel_r) |-> !mpo)
		else $error("mpo high while not selected");
	chk_irq_off: assert property (!ien_r && !$past(ien_r) |-> !irq)
		else $error("irq high with nothing enabled");
endmodule

bind uart_echo_wakeup uart_echo_wakeup_chk u_chk
(
	.mclk(mclk), .sys_rst(sys_rst), .avs_chipselect(avs_chipselect),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.rxd(rxd), .txd(txd), .mpo(mpo), .irq(irq)
);

`default_nettype wire

// ### bench/uart_remote_station.sv
// remote serial station that sends frames toward the channel
// assumes mclk at 200 mhz; line idles high between frames
`include "uart_echo_defs.svh"
`default_nettype none

module uart_remote_station
(
	// clock
	input wire logic mclk,
	// serial line toward the channel
	output var logic rxd
);
	timeunit 1ns;
	timeprecision 1ps;

	initial rxd = 1'b1;

	// start, eight data bits lsb first, stop; each bit one baud period
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge mclk);
			rxd <= f[i];
			repeat (`CLK_HZ / `BAUD_HZ - 1) @(posedge mclk);
		end
	endtask
endmodule

`default_nettype wire

// ### verilog/uart_echo_defs.svh
// register offsets, field positions, reset values and timing counts
// for the echo and wake-up serial channel; definitions only.
`ifndef UART_ECHO_DEFS_SVH
`define UART_ECHO_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_MODE_ONE       6'h00
`define OFS_MODE_TWO       6'h04
`define OFS_CTRL           6'h08
`define OFS_STATUS         6'h0c
`define OFS_RX_DATA        6'h10
`define OFS_TX_DATA        6'h14
`define OFS_IRQ_STATUS     6'h18
`define OFS_IRQ_CLEAR      6'h1c
`define OFS_IRQ_ENABLE     6'h20

// ----------------------------------------
// field positions
// ----------------------------------------
`define MODE1_SEVEN_BIT    0
`define MODE1_WAKE_UP      1
`define MODE2_MPO_SEL      0
`define MODE2_CHMODE_LO    6
`define MODE2_CHMODE_HI    7
`define CTRL_RX_EN         0
`define CTRL_TX_EN         1
`define ST_RX_READY        0
`define ST_TX_EMPTY        1
`define ST_OVERRUN         2
`define ST_ECHO_ACTIVE     3
`define ST_QUEUE_FULL      4
`define RXD_ADDR_FLAG      8
`define IRQ_RX_CHAR        0
`define IRQ_OVERRUN        1
`define IRQ_TX_DONE        2

// ----------------------------------------
// encodings, reset values and queue depth
// ----------------------------------------
`define CHMODE_NORMAL      2'h0
`define CHMODE_ECHO        2'h1
`define MODE1_RESET        2'h0
`define MODE2_RESET        8'h00
`define CTRL_RESET         2'h0
`define IRQ_ENABLE_RESET   3'h0
`define QUEUE_DEPTH        2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ             200000000
`define BAUD_HZ            31250
`define OVERSAMPLE         16
`define TICK_CYCLES        (`CLK_HZ / (`BAUD_HZ * `OVERSAMPLE))
`define HALF_BIT_TICKS     4'h7
`define LAST_TICK          4'hf

`endif

// ### verilog/uart_echo_pkg.sv
// types shared by the echo and wake-up serial channel
// assumes the defs header supplies all numbers
`default_nettype none

package uart_echo_pkg;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;

	// the whole state of the channel, registered in one process
	typedef struct packed {
		logic [2:0]       sync;
		logic             rx_lvl;
		logic [8:0]       div;
		logic             tick;
		rx_state_t        rx_st;
		logic [3:0]       rx_tk;
		logic [2:0]       rx_bit;
		logic [7:0]       rx_sh;
		logic [2:0][8:0]  q;
		logic [1:0]       head;
		logic [1:0]       tail;
		logic [1:0]       cnt;
		logic [1:0]       mode1;
		logic [7:0]       mode2;
		logic [1:0]       ctrl;
		tx_state_t        tx_st;
		logic [3:0]       tx_tk;
		logic [2:0]       tx_bit;
		logic [7:0]       tx_sh;
		logic [7:0]       thr;
		logic             thr_full;
		logic             tx_line;
		logic             echo_act;
		logic             echo_bit;
		logic             txd;
		logic             mpo;
		logic             overrun;
		logic [2:0]       irq_st;
		logic [2:0]       irq_en;
		logic             ack;
		logic [31:0]      rdata;
	} chan_state_t;

endpackage

`default_nettype wire

// ### verilog/uart_echo_wakeup.sv
// serial channel with automatic echo and wake-up address recognition,
// registers on an avalon-mm slave with one wait state per access.
// assumes rxd is asynchronous to mclk; mclk runs at 200 mhz.
//
// Behaviour
// - echo resends received stream retimed by rx clock
// - echo: rx to host works, host tx blocked
// - mode two bits 7:6 = 01 selects echo
// - leaving echo mid-frame: echo until stop sent
// - echo works without transmitter enable
// - disabled wake-up receiver still flags address characters
// - seven-bit mode: eighth bit is address flag
// - rx off, wake-up on: address char queued, sets ready
// - rx off: data chars dropped until enabled
// - receive ready selectable onto multi-purpose output
// - access spans chip select and strobe overlap
// - three queued characters plus one in shift
// - frame: start, eight data, stop, 31.25k
`include "uart_echo_defs.svh"
`default_nettype none

module uart_echo_wakeup
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// avalon-mm slave
	input  wire logic        avs_chipselect,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// serial link
	input  wire logic        rxd,
	output logic             txd,
	// host side pins
	output logic             mpo,
	output logic             irq
);

	uart_echo_pkg::chan_state_t s_r;
	uart_echo_pkg::chan_state_t s_nxt;

	// register select, used by both the read mux and the write decode
	function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
		hit = (a[5:2] == ofs[5:2]);
	endfunction

	logic       access;
	logic       wr_go;
	logic       rd_go;
	logic [8:0] rx_char;
	logic       rx_load;
	logic       pop;
	logic [2:0] irq_set;
	logic [2:0] irq_clr;
	logic       echo_req;

	// ------------------------------------------------------------
	// bus handshake
	// ------------------------------------------------------------
	// the access lives while chip select and a strobe overlap
	assign access          = avs_chipselect & (avs_read | avs_write);
	assign avs_waitrequest = access & ~s_r.ack;
	assign wr_go           = access & s_r.ack & avs_write & avs_byteenable[0];
	assign rd_go           = access & s_r.ack & avs_read;
	assign avs_readdata    = s_r.rdata;
	assign txd             = s_r.txd;
	assign mpo             = s_r.mpo;
	assign irq             = |(s_r.irq_st & s_r.irq_en);
	assign echo_req        = (s_r.mode2[`MODE2_CHMODE_HI:`MODE2_CHMODE_LO] == `CHMODE_ECHO);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_nxt   = s_r;
		rx_load = 1'b0;
		rx_char = 9'h000;
		irq_set = 3'h0;
		irq_clr = 3'h0;
		pop     = 1'b0;

		// one wait state, then the answer edge
		s_nxt.ack = access & ~s_r.ack;

		// three stages; a level counts once the last two agree
		s_nxt.sync = {s_r.sync[1:0], rxd};
		if (s_r.sync[2] == s_r.sync[1])
			s_nxt.rx_lvl = s_r.sync[2];

		// 16x oversample enable
		s_nxt.tick = 1'b0;
		if (s_r.div == 9'(`TICK_CYCLES - 1))
		begin
			s_nxt.div  = 9'h000;
			s_nxt.tick = 1'b1;
		end
		else
			s_nxt.div = s_r.div + 9'h001;

		// receiver: start, eight data bits, one stop bit
		if (s_r.tick)
		begin
			s_nxt.rx_tk = s_r.rx_tk + 4'h1;
			case (s_r.rx_st)
				uart_echo_pkg::RX_IDLE:
				begin
					s_nxt.rx_tk = 4'h0;
					if (!s_r.rx_lvl)
						s_nxt.rx_st = uart_echo_pkg::RX_START;
				end
				uart_echo_pkg::RX_START:
				begin
					if (s_r.rx_tk == `HALF_BIT_TICKS)
					begin
						s_nxt.rx_tk  = 4'h0;
						s_nxt.rx_bit = 3'h0;
						// a glitch shorter than half a bit is not a start
						s_nxt.rx_st  = s_r.rx_lvl ? uart_echo_pkg::RX_IDLE
						                          : uart_echo_pkg::RX_DATA;
					end
				end
				uart_echo_pkg::RX_DATA:
				begin
					if (s_r.rx_tk == `LAST_TICK)
					begin
						s_nxt.rx_sh  = {s_r.rx_lvl, s_r.rx_sh[7:1]};  // lsb first
						s_nxt.rx_bit = s_r.rx_bit + 3'h1;
						if (s_r.rx_bit == 3'h7)
							s_nxt.rx_st = uart_echo_pkg::RX_STOP;
					end
				end
				uart_echo_pkg::RX_STOP:
				begin
					if (s_r.rx_tk == `LAST_TICK)
					begin
						s_nxt.rx_st = uart_echo_pkg::RX_IDLE;
						// a low stop bit is a framing fault: the character is dropped
						if (s_r.rx_lvl)
						begin
							if (s_r.mode1[`MODE1_SEVEN_BIT])
								rx_char = {s_r.rx_sh[7], 1'b0, s_r.rx_sh[6:0]};
							else
								rx_char = {1'b0, s_r.rx_sh};
							if (s_r.ctrl[`CTRL_RX_EN])
								rx_load = 1'b1;
							else if (s_r.mode1[`MODE1_WAKE_UP])
								rx_load = rx_char[`RXD_ADDR_FLAG];
						end
					end
				end
				default:
					s_nxt.rx_st = uart_echo_pkg::RX_IDLE;
			endcase
		end

		// queue pops on a read of the data register with data present
		if (rd_go && hit(avs_address, `OFS_RX_DATA) && (s_r.cnt != 2'h0))
		begin
			pop        = 1'b1;
			s_nxt.head = (s_r.head == 2'h2) ? 2'h0 : s_r.head + 2'h1;
		end

		// three holding slots; the shift stage is the fourth character
		if (rx_load)
		begin
			if (s_r.cnt == `QUEUE_DEPTH && !pop)
			begin
				s_nxt.overrun = 1'b1;
				irq_set[`IRQ_OVERRUN] = 1'b1;
			end
			else
			begin
				s_nxt.q[s_r.tail] = rx_char;
				s_nxt.tail = (s_r.tail == 2'h2) ? 2'h0 : s_r.tail + 2'h1;
				irq_set[`IRQ_RX_CHAR] = 1'b1;
			end
		end
		if (rx_load && !(s_r.cnt == `QUEUE_DEPTH && !pop) && !pop)
			s_nxt.cnt = s_r.cnt + 2'h1;
		else if (pop && !rx_load)
			s_nxt.cnt = s_r.cnt - 2'h1;

		// echo: retime the line on the receiver's tick; no tx enable needed
		if (s_r.tick)
			s_nxt.echo_bit = s_r.rx_lvl;
		// after leaving echo, hold it until the frame ends and a stop is out
		if (echo_req)
			s_nxt.echo_act = 1'b1;
		else if ((s_r.rx_st == uart_echo_pkg::RX_IDLE) && s_r.echo_bit)
			s_nxt.echo_act = 1'b0;

		// transmitter: eight data bits, one stop bit
		if (s_r.tick)
		begin
			s_nxt.tx_tk = s_r.tx_tk + 4'h1;
			case (s_r.tx_st)
				uart_echo_pkg::TX_IDLE:
				begin
					s_nxt.tx_tk   = 4'h0;
					s_nxt.tx_line = 1'b1;
					if (s_r.thr_full && s_r.ctrl[`CTRL_TX_EN] && !s_r.echo_act)
					begin
						s_nxt.tx_sh    = s_r.thr;
						s_nxt.thr_full = 1'b0;
						s_nxt.tx_line  = 1'b0;
						s_nxt.tx_st    = uart_echo_pkg::TX_START;
					end
				end
				uart_echo_pkg::TX_START:
				begin
					if (s_r.tx_tk == `LAST_TICK)
					begin
						s_nxt.tx_bit  = 3'h0;
						s_nxt.tx_line = s_r.tx_sh[0];
						s_nxt.tx_st   = uart_echo_pkg::TX_DATA;
					end
				end
				uart_echo_pkg::TX_DATA:
				begin
					if (s_r.tx_tk == `LAST_TICK)
					begin
						s_nxt.tx_sh  = {1'b0, s_r.tx_sh[7:1]};
						s_nxt.tx_bit = s_r.tx_bit + 3'h1;
						if (s_r.tx_bit == 3'h7)
						begin
							s_nxt.tx_line = 1'b1;
							s_nxt.tx_st   = uart_echo_pkg::TX_STOP;
						end
						else
							s_nxt.tx_line = s_r.tx_sh[1];
					end
				end
				uart_echo_pkg::TX_STOP:
				begin
					if (s_r.tx_tk == `LAST_TICK)
					begin
						s_nxt.tx_st = uart_echo_pkg::TX_IDLE;
						irq_set[`IRQ_TX_DONE] = 1'b1;
					end
				end
				default:
					s_nxt.tx_st = uart_echo_pkg::TX_IDLE;
			endcase
		end

		// line driver: echo path or the host path
		s_nxt.txd = s_r.echo_act ? s_r.echo_bit : s_r.tx_line;
		// receive ready onto the multi-purpose pin when selected
		s_nxt.mpo = s_r.mode2[`MODE2_MPO_SEL] & (s_nxt.cnt != 2'h0);

		// register writes take effect on the answer edge
		if (wr_go)
		begin
			if (hit(avs_address, `OFS_MODE_ONE))
				s_nxt.mode1 = avs_writedata[1:0];
			if (hit(avs_address, `OFS_MODE_TWO))
				s_nxt.mode2 = avs_writedata[7:0];
			if (hit(avs_address, `OFS_CTRL))
				s_nxt.ctrl = avs_writedata[1:0];
			if (hit(avs_address, `OFS_IRQ_ENABLE))
				s_nxt.irq_en = avs_writedata[2:0];
			if (hit(avs_address, `OFS_IRQ_CLEAR))
				irq_clr = avs_writedata[2:0];
			// reading status clears nothing; overrun clears with bit 1 of the clear word
			if (hit(avs_address, `OFS_IRQ_CLEAR) && avs_writedata[`IRQ_OVERRUN])
				s_nxt.overrun = s_nxt.overrun & irq_set[`IRQ_OVERRUN];
			// while echoing, host characters never reach the line
			if (hit(avs_address, `OFS_TX_DATA) && !s_r.echo_act && !s_r.thr_full)
			begin
				s_nxt.thr      = avs_writedata[7:0];
				s_nxt.thr_full = 1'b1;
			end
		end
		// a set in the clearing cycle wins
		s_nxt.irq_st = (s_r.irq_st & ~irq_clr) | irq_set;

		// read data captured in the wait cycle, shown on the answer edge
		if (access && !s_r.ack)
		begin
			s_nxt.rdata = 32'h0000_0000;
			if (hit(avs_address, `OFS_MODE_ONE))
				s_nxt.rdata[1:0] = s_r.mode1;
			else if (hit(avs_address, `OFS_MODE_TWO))
				s_nxt.rdata[7:0] = s_r.mode2;
			else if (hit(avs_address, `OFS_CTRL))
				s_nxt.rdata[1:0] = s_r.ctrl;
			else if (hit(avs_address, `OFS_STATUS))
			begin
				s_nxt.rdata[`ST_RX_READY]    = (s_r.cnt != 2'h0);
				s_nxt.rdata[`ST_TX_EMPTY]    = ~s_r.thr_full &
				                               (s_r.tx_st == uart_echo_pkg::TX_IDLE);
				s_nxt.rdata[`ST_OVERRUN]     = s_r.overrun;
				s_nxt.rdata[`ST_ECHO_ACTIVE] = s_r.echo_act;
				s_nxt.rdata[`ST_QUEUE_FULL]  = (s_r.cnt == `QUEUE_DEPTH);
			end
			else if (hit(avs_address, `OFS_RX_DATA))
				s_nxt.rdata[8:0] = s_r.q[s_r.head];
			else if (hit(avs_address, `OFS_IRQ_STATUS))
				s_nxt.rdata[2:0] = s_r.irq_st;
			else if (hit(avs_address, `OFS_IRQ_ENABLE))
				s_nxt.rdata[2:0] = s_r.irq_en;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// synchronous reset; the line idles high
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			s_r          <= '0;
			s_r.sync     <= 3'h7;
			s_r.rx_lvl   <= 1'b1;
			s_r.rx_st    <= uart_echo_pkg::RX_IDLE;
			s_r.tx_st    <= uart_echo_pkg::TX_IDLE;
			s_r.mode1    <= `MODE1_RESET;
			s_r.mode2    <= `MODE2_RESET;
			s_r.ctrl     <= `CTRL_RESET;
			s_r.irq_en   <= `IRQ_ENABLE_RESET;
			s_r.tx_line  <= 1'b1;
			s_r.echo_bit <= 1'b1;
			s_r.txd      <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

endmodule

`default_nettype wire
